// ### design/mtc_main_timer_core.sv
// Summary of operation
// - On channel-7 compare, masked pins take the compare-7 data bits.
// - Channel-7 data wins over a simultaneous lower-channel action on masked pins.
// - 16-bit up-counter; writes land only while special_mode_n is low.
// - A counter write leaves the prescaler alone, so the first period varies.
// - Timer enable low halts counter and the divide-by-64 clock.
// - Stop-in-wait halts timer, accumulators, modulus counter; interrupts masked in wait.
// - Stop-in-background halts timer and modulus counter; accumulator keeps running.
// - Fast clear: capture read or compare write clears that channel's flag.
// - Fast clear: any counter access clears the overflow flag.
// - Fast clear: pulse count accesses clear accumulator A or B flags.
// - Two-bit action per compare: disconnect, toggle, clear, set.
// - Non-zero action on a compare channel forces the pin to output, ignoring port direction.
// - Edge select per capture: off, rising, falling, both.
// - Channel interrupt requested for each set flag with enable set.
// - Overflow interrupt requested while flag and its enable are set.
// - Counter reset enable makes channel-7 compare reset the counter.
// - Prescale codes 0..5 divide by 1..32; codes 6, 7 by 32.
// - New prescale applies only when all prescaler stages are zero.
// - Writing one clears a channel flag; zero leaves it.
// - Overflow flag sets on wrap; cleared by writing bit 7.
// - Select bit: zero is capture, one is compare.
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

module mtc_main_timer_core #(
  parameter int unsigned ADDR_W = 10,
  parameter int unsigned CHANS  = 8
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  ce,
  input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [ADDR_W-1:0]     s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  special_mode_n,
  input  wire logic                  wait_mode,
  input  wire logic                  background_mode,
  input  wire logic [CHANS-1:0]      timer_port_in,
  input  wire logic [CHANS-1:0]      port_direction,
  output logic [CHANS-1:0]           timer_port_out,
  output logic [CHANS-1:0]           timer_port_oe,
  output logic                       port_pullup_enable,
  output logic                       port_drive_reduce,
  output logic [CHANS-1:0]           channel_irq,
  output logic                       overflow_irq,
  output logic                       div64_tick,
  output logic                       accum_halt,
  output logic                       modulus_halt,
  output logic                       accum_a_flag_clear,
  output logic                       accum_b_flag_clear
);
  import mtc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Register state

  logic [CHANS-1:0]            capture_compare_select_q;
  logic [CHANS-1:0]            compare7_mask_q;
  logic [CHANS-1:0]            compare7_data_q;
  logic [7:0]                  timer_system_control_q;
  logic [2*CHANS-1:0]          output_action_q;
  logic [2*CHANS-1:0]          edge_select_q;
  logic [CHANS-1:0]            channel_irq_enables_q;
  logic [7:0]                  timer_misc_control_q;
  logic [CHANS-1:0]            channel_event_flag_q;
  logic                        overflow_flag_q;
  logic [15:0]                 main_counter_q;
  logic [15:0]                 channel_value_q [CHANS];
  logic [PRESCALE_STAGES-1:0]  prescale_cnt_q;
  logic [2:0]                  prescale_active_q;
  logic                        count_new_q;
  logic [CHANS-1:0]            pin_prev_q;

  // Bus slave state
  logic                        aw_held_q;
  logic                        w_held_q;
  logic [ADDR_W-1:0]           awaddr_q;
  logic [31:0]                 wdata_q;
  logic [3:0]                  wstrb_q;

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  logic                        wr_fire;
  logic                        rd_fire;
  logic [7:0]                  wr_idx;
  logic [7:0]                  rd_idx;
  logic                        wr_chan;
  logic                        rd_chan;
  logic [2:0]                  wr_ch;
  logic [2:0]                  rd_ch;
  logic [7:0]                  wbyte;

  assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign wr_idx  = awaddr_q[9:2];
  assign rd_idx  = s_axi_araddr[9:2];
  assign wr_chan = (wr_idx[7:4] == IDX_CHANNEL_HIGH) && !wr_idx[0];
  assign rd_chan = (rd_idx[7:4] == IDX_CHANNEL_HIGH) && !rd_idx[0];
  assign wr_ch   = wr_idx[3:1];
  assign rd_ch   = rd_idx[3:1];
  // Eight-bit registers take lane 0 only
  assign wbyte   = wstrb_q[0] ? wdata_q[7:0] : REG8_RESET;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] be);
    merge16 = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
  endfunction : merge16

  function automatic logic is_mapped(input logic [7:0] idx);
    logic chan;
    chan = (idx[7:4] == IDX_CHANNEL_HIGH) && !idx[0];
    is_mapped = chan || (idx inside {IDX_CAPTURE_SELECT, IDX_COMPARE7_MASK,
      IDX_COMPARE7_DATA, IDX_MAIN_COUNTER, IDX_SYSTEM_CONTROL, IDX_ACTION_UPPER,
      IDX_ACTION_LOWER, IDX_EDGE_UPPER, IDX_EDGE_LOWER, IDX_CHAN_IRQ_EN,
      IDX_MISC_CONTROL, IDX_CHANNEL_FLAGS, IDX_OVERFLOW_FLAGS, IDX_PULSE_COUNT_3,
      IDX_PULSE_COUNT_2, IDX_PULSE_COUNT_1, IDX_PULSE_COUNT_0});
  endfunction : is_mapped

  ////////////////////////////////////////////////////////////////////////////
  // Control fields

  logic        fast_clear;
  logic        wait_stop;
  logic        prescale_run;
  logic        count_run;
  logic        counter_reset_en;
  logic [2:0]  prescale_req;
  logic [5:0]  prescale_mask;
  logic        count_tick;
  logic        match7_reset;
  logic [CHANS-1:0] compare_hit;
  logic [CHANS-1:0] capture_hit;

  assign fast_clear       = timer_system_control_q[FAST_FLAG_CLEAR_BIT];
  assign wait_stop        = wait_mode && timer_system_control_q[STOP_IN_WAIT_BIT];
  // Prescaler keeps the divide-by-64 alive in background mode
  assign prescale_run     = timer_system_control_q[TIMER_ENABLE_BIT] && !wait_stop;
  assign count_run        = prescale_run &&
    !(background_mode && timer_system_control_q[STOP_IN_BACKGROUND_BIT]);
  assign counter_reset_en = timer_misc_control_q[COUNTER_RESET_BIT];
  assign prescale_req     = timer_misc_control_q[PRESCALE_LSB +: PRESCALE_W];
  assign prescale_mask    = 6'((7'h01 << prescale_active_q) - 7'h01);
  assign count_tick       = count_run && ((prescale_cnt_q & prescale_mask) == prescale_mask);
  assign match7_reset     = counter_reset_en && capture_compare_select_q[CHANS-1] &&
                            (main_counter_q == channel_value_q[CHANS-1]);

  always_comb begin
    for (int n = 0; n < CHANS; n++) begin
      compare_hit[n] = capture_compare_select_q[n] && count_new_q &&
                       (main_counter_q == channel_value_q[n]);
      unique case (edge_select_q[2*n +: 2])
        2'b01:   capture_hit[n] = timer_port_in[n] && !pin_prev_q[n];
        2'b10:   capture_hit[n] = !timer_port_in[n] && pin_prev_q[n];
        2'b11:   capture_hit[n] = timer_port_in[n] != pin_prev_q[n];
        default: capture_hit[n] = 1'b0;
      endcase
      capture_hit[n] = capture_hit[n] && !capture_compare_select_q[n];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prescale_cnt_q    <= '0;
      prescale_active_q <= '0;
      div64_tick        <= 1'b0;
    end else if (ce) begin
      if (prescale_run) begin
        prescale_cnt_q <= prescale_cnt_q + 6'h01;
      end
      // Switching mid-period would give a runt tick
      if (prescale_cnt_q == '0) begin
        prescale_active_q <= (prescale_req > PRESCALE_MAX_CODE) ? PRESCALE_MAX_CODE
                                                                : prescale_req;
      end
      div64_tick <= prescale_run && (prescale_cnt_q == DIV64_TERMINAL);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main counter

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      main_counter_q <= COUNTER_RESET;
      count_new_q    <= 1'b0;
    end else if (ce) begin
      count_new_q <= count_tick;
      // Prescaler phase is not touched, so the next period may be short
      if (wr_fire && wr_idx == IDX_MAIN_COUNTER && !special_mode_n) begin
        main_counter_q <= merge16(main_counter_q, wdata_q, wstrb_q);
      end else if (count_tick) begin
        main_counter_q <= match7_reset ? COUNTER_RESET : main_counter_q + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel values: capture latches the counter, compare takes writes

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_prev_q <= '0;
      for (int n = 0; n < CHANS; n++) begin
        channel_value_q[n] <= COUNTER_RESET;
      end
    end else if (ce) begin
      pin_prev_q <= timer_port_in;
      for (int n = 0; n < CHANS; n++) begin
        if (capture_hit[n]) begin
          channel_value_q[n] <= main_counter_q;
        end else if (wr_fire && wr_chan && wr_ch == 3'(n) && capture_compare_select_q[n]) begin
          channel_value_q[n] <= merge16(channel_value_q[n], wdata_q, wstrb_q);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags; a set in the same cycle as a clear wins

  logic [CHANS-1:0] chan_clear;
  logic             ovf_clear;
  logic             ovf_set;

  always_comb begin
    chan_clear = '0;
    if (wr_fire && wr_idx == IDX_CHANNEL_FLAGS) begin
      chan_clear = wbyte;
    end
    if (fast_clear && wr_fire && wr_chan && capture_compare_select_q[wr_ch]) begin
      chan_clear[wr_ch] = 1'b1;
    end
    if (fast_clear && rd_fire && rd_chan && !capture_compare_select_q[rd_ch]) begin
      chan_clear[rd_ch] = 1'b1;
    end
  end

  assign ovf_clear = (wr_fire && wr_idx == IDX_OVERFLOW_FLAGS && wbyte[OVERFLOW_FLAG_BIT]) ||
                     (fast_clear && ((wr_fire && wr_idx == IDX_MAIN_COUNTER) ||
                                     (rd_fire && rd_idx == IDX_MAIN_COUNTER)));
  // A compare-7 reset at all ones is not a wrap
  assign ovf_set   = count_tick && !match7_reset && (main_counter_q == COUNTER_WRAP);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      channel_event_flag_q <= '0;
      overflow_flag_q      <= 1'b0;
    end else if (ce) begin
      channel_event_flag_q <= (channel_event_flag_q & ~chan_clear) |
                              compare_hit | capture_hit;
      overflow_flag_q      <= (overflow_flag_q && !ovf_clear) || ovf_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin actions

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_port_out <= '0;
      timer_port_oe  <= '0;
    end else if (ce) begin
      for (int n = 0; n < CHANS; n++) begin
        if (compare_hit[CHANS-1] && compare7_mask_q[n]) begin
          timer_port_out[n] <= compare7_data_q[n];
        end else if (compare_hit[n]) begin
          unique case (output_action_q[2*n +: 2])
            2'b01:   timer_port_out[n] <= !timer_port_out[n];
            2'b10:   timer_port_out[n] <= 1'b0;
            2'b11:   timer_port_out[n] <= 1'b1;
            default: timer_port_out[n] <= timer_port_out[n];
          endcase
        end
        timer_port_oe[n] <= (capture_compare_select_q[n] &&
                             (output_action_q[2*n +: 2] != 2'b00 || compare7_mask_q[n])) ?
                            1'b1 : port_direction[n];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Requests and side outputs

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      channel_irq        <= '0;
      overflow_irq       <= 1'b0;
      port_pullup_enable <= 1'b0;
      port_drive_reduce  <= 1'b0;
      accum_halt         <= 1'b0;
      modulus_halt       <= 1'b0;
      accum_a_flag_clear <= 1'b0;
      accum_b_flag_clear <= 1'b0;
    end else if (ce) begin
      // Held low in stopped wait so a timer event cannot wake the core
      channel_irq  <= wait_stop ? '0 : channel_event_flag_q & channel_irq_enables_q;
      overflow_irq <= !wait_stop && overflow_flag_q &&
                      timer_misc_control_q[OVERFLOW_IRQ_BIT];
      port_pullup_enable <= timer_misc_control_q[PULLUP_ENABLE_BIT];
      port_drive_reduce  <= timer_misc_control_q[DRIVE_REDUCE_BIT];
      accum_halt   <= wait_stop;
      modulus_halt <= wait_stop || (background_mode &&
                      timer_system_control_q[STOP_IN_BACKGROUND_BIT]);
      accum_a_flag_clear <= fast_clear &&
        ((wr_fire && (wr_idx == IDX_PULSE_COUNT_3 || wr_idx == IDX_PULSE_COUNT_2)) ||
         (rd_fire && (rd_idx == IDX_PULSE_COUNT_3 || rd_idx == IDX_PULSE_COUNT_2)));
      accum_b_flag_clear <= fast_clear &&
        ((wr_fire && (wr_idx == IDX_PULSE_COUNT_1 || wr_idx == IDX_PULSE_COUNT_0)) ||
         (rd_fire && (rd_idx == IDX_PULSE_COUNT_1 || rd_idx == IDX_PULSE_COUNT_0)));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Plain control registers

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capture_compare_select_q <= REG8_RESET;
      compare7_mask_q          <= REG8_RESET;
      compare7_data_q          <= REG8_RESET;
      timer_system_control_q   <= REG8_RESET;
      output_action_q          <= {REG8_RESET, REG8_RESET};
      edge_select_q            <= {REG8_RESET, REG8_RESET};
      channel_irq_enables_q    <= REG8_RESET;
      timer_misc_control_q     <= REG8_RESET;
    end else if (ce && wr_fire && wstrb_q[0]) begin
      unique case (wr_idx)
        IDX_CAPTURE_SELECT: capture_compare_select_q <= wbyte;
        IDX_COMPARE7_MASK:  compare7_mask_q          <= wbyte;
        IDX_COMPARE7_DATA:  compare7_data_q          <= wbyte;
        IDX_SYSTEM_CONTROL: timer_system_control_q   <= {wbyte[7:4], 4'h0};
        IDX_ACTION_UPPER:   output_action_q[15:8]    <= wbyte;
        IDX_ACTION_LOWER:   output_action_q[7:0]     <= wbyte;
        IDX_EDGE_UPPER:     edge_select_q[15:8]      <= wbyte;
        IDX_EDGE_LOWER:     edge_select_q[7:0]       <= wbyte;
        IDX_CHAN_IRQ_EN:    channel_irq_enables_q    <= wbyte;
        IDX_MISC_CONTROL:   timer_misc_control_q     <= {wbyte[7], 1'b0, wbyte[5:0]};
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave

  logic [31:0] rd_value;

  always_comb begin
    rd_value = '0;
    if (rd_chan) begin
      rd_value[15:0] = channel_value_q[rd_ch];
    end else begin
      unique case (rd_idx)
        IDX_CAPTURE_SELECT: rd_value[7:0]  = capture_compare_select_q;
        IDX_COMPARE7_MASK:  rd_value[7:0]  = compare7_mask_q;
        IDX_COMPARE7_DATA:  rd_value[7:0]  = compare7_data_q;
        IDX_MAIN_COUNTER:   rd_value[15:0] = main_counter_q;
        IDX_SYSTEM_CONTROL: rd_value[7:0]  = timer_system_control_q;
        IDX_ACTION_UPPER:   rd_value[7:0]  = output_action_q[15:8];
        IDX_ACTION_LOWER:   rd_value[7:0]  = output_action_q[7:0];
        IDX_EDGE_UPPER:     rd_value[7:0]  = edge_select_q[15:8];
        IDX_EDGE_LOWER:     rd_value[7:0]  = edge_select_q[7:0];
        IDX_CHAN_IRQ_EN:    rd_value[7:0]  = channel_irq_enables_q;
        IDX_MISC_CONTROL:   rd_value[7:0]  = timer_misc_control_q;
        IDX_CHANNEL_FLAGS:  rd_value[7:0]  = channel_event_flag_q;
        IDX_OVERFLOW_FLAGS: rd_value[OVERFLOW_FLAG_BIT] = overflow_flag_q;
        default: ;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      awaddr_q      <= '0;
      wdata_q       <= '0;
      wstrb_q       <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q     <= 1'b1;
        awaddr_q      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q     <= 1'b1;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= is_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        aw_held_q     <= 1'b0;
        w_held_q      <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (ce) begin
      if (rd_fire) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_value;
        s_axi_rresp   <= is_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule : mtc_main_timer_core

// ### design/mtc_pkg.sv
package mtc_pkg;

  // Register indices; byte address on the bus is four times the index
  localparam logic [7:0] IDX_CAPTURE_SELECT = 8'h80;
  localparam logic [7:0] IDX_COMPARE7_MASK  = 8'h82;
  localparam logic [7:0] IDX_COMPARE7_DATA  = 8'h83;
  localparam logic [7:0] IDX_MAIN_COUNTER   = 8'h84;
  localparam logic [7:0] IDX_SYSTEM_CONTROL = 8'h86;
  localparam logic [7:0] IDX_ACTION_UPPER   = 8'h88;
  localparam logic [7:0] IDX_ACTION_LOWER   = 8'h89;
  localparam logic [7:0] IDX_EDGE_UPPER     = 8'h8a;
  localparam logic [7:0] IDX_EDGE_LOWER     = 8'h8b;
  localparam logic [7:0] IDX_CHAN_IRQ_EN    = 8'h8c;
  localparam logic [7:0] IDX_MISC_CONTROL   = 8'h8d;
  localparam logic [7:0] IDX_CHANNEL_FLAGS  = 8'h8e;
  localparam logic [7:0] IDX_OVERFLOW_FLAGS = 8'h8f;
  localparam logic [3:0] IDX_CHANNEL_HIGH   = 4'h9;
  localparam logic [7:0] IDX_PULSE_COUNT_3  = 8'ha2;
  localparam logic [7:0] IDX_PULSE_COUNT_2  = 8'ha3;
  localparam logic [7:0] IDX_PULSE_COUNT_1  = 8'ha4;
  localparam logic [7:0] IDX_PULSE_COUNT_0  = 8'ha5;

  // System control fields
  localparam int unsigned TIMER_ENABLE_BIT       = 7;
  localparam int unsigned STOP_IN_WAIT_BIT       = 6;
  localparam int unsigned STOP_IN_BACKGROUND_BIT = 5;
  localparam int unsigned FAST_FLAG_CLEAR_BIT    = 4;

  // Misc control fields
  localparam int unsigned OVERFLOW_IRQ_BIT       = 7;
  localparam int unsigned PULLUP_ENABLE_BIT      = 5;
  localparam int unsigned DRIVE_REDUCE_BIT       = 4;
  localparam int unsigned COUNTER_RESET_BIT      = 3;
  localparam int unsigned PRESCALE_LSB           = 0;
  localparam int unsigned PRESCALE_W             = 3;
  localparam int unsigned OVERFLOW_FLAG_BIT      = 7;

  // Prescaler
  localparam logic [2:0] PRESCALE_MAX_CODE  = 3'h5;
  localparam int unsigned PRESCALE_STAGES   = 6;
  localparam logic [5:0] DIV64_TERMINAL     = 6'h3f;

  // Reset values
  localparam logic [7:0]  REG8_RESET    = 8'h00;
  localparam logic [15:0] COUNTER_RESET = 16'h0000;
  localparam logic [15:0] COUNTER_WRAP  = 16'hffff;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : mtc_pkg

// ### sim/mtc_core_sva.sv
`timescale 1ns/1ps
module mtc_core_sva (
  input wire logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input wire logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid,
  input wire logic accum_halt, modulus_halt, div64_tick, overflow_irq, accum_a_flag_clear,
  input wire logic [1:0] s_axi_bresp,
  input wire logic [7:0] channel_irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  a_write_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_halt_nest: assert property (accum_halt |-> modulus_halt)
    else $error("modulus runs in wait stop");
  a_wait_quiet: assert property (accum_halt && $past(accum_halt) |-> !overflow_irq && channel_irq == 8'h00)
    else $error("interrupt during wait stop");
  a_halt_tick: assert property (accum_halt && $past(accum_halt) |-> !div64_tick)
    else $error("tick during wait stop");
  a_tick_gap: assert property (div64_tick |=> !div64_tick [*8])
    else $error("tick too frequent");
  a_clear_pulse: assert property (accum_a_flag_clear |=> !accum_a_flag_clear)
    else $error("clear pulse too long");
endmodule : mtc_core_sva
bind mtc_main_timer_core mtc_core_sva u_sva (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .accum_halt, .modulus_halt, .div64_tick, .overflow_irq, .accum_a_flag_clear,
  .s_axi_bresp, .channel_irq);

// ### sim/mtc_main_timer_core_tb.sv
`timescale 1ns/1ps
module mtc_main_timer_core_tb;
  import mtc_pkg::*;
  logic aclk = 0, aresetn = 0, ce = 1, special_mode_n = 1, wait_mode = 0, background_mode = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [9:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rdat, v;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [7:0] port_direction = '0, ext_v = '0, timer_port_in, timer_port_out, timer_port_oe, channel_irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, rrsp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, port_pullup_enable;
  logic port_drive_reduce, overflow_irq, div64_tick, accum_halt, modulus_halt;
  logic accum_a_flag_clear, accum_b_flag_clear;
  int errors = 0, check_count = 0;
  always #4 aclk = ~aclk;
  mtc_pin_model pm (.*);
  mtc_main_timer_core dut (.*);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic tmo(input int n);
    if (n == 0) begin
      errors++;
      stop_test();
    end
  endtask : tmo
  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    int n;
    n = 50;
    @(posedge aclk);
    s_axi_awaddr <= {i, 2'b00};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      n--;
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid && n > 0);
    s_axi_bready <= 0;
    tmo(n);
  endtask : wr
  task automatic rd(input logic [7:0] i);
    int n;
    n = 50;
    @(posedge aclk);
    s_axi_araddr <= {i, 2'b00};
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      n--;
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid && n > 0);
    rdat = s_axi_rdata;
    rrsp = s_axi_rresp;
    s_axi_rready <= 0;
    tmo(n);
  endtask : rd
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(34092));
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    wr(IDX_MISC_CONTROL, 32'h0000_0030);
    rd(IDX_MISC_CONTROL);
    chk(rdat, 32'h0000_0030);
    chk(port_pullup_enable & port_drive_reduce, 1);
    rd(8'h81);
    chk(rrsp, RESP_SLVERR);
    v = $urandom & 32'h0000_ffff;
    wr(IDX_MAIN_COUNTER, v);
    rd(IDX_MAIN_COUNTER);
    chk(rdat, 0);
    special_mode_n <= 0;
    wr(IDX_MAIN_COUNTER, v);
    rd(IDX_MAIN_COUNTER);
    chk(rdat, v);
    $display("register and counter tests done");
    wr(IDX_CAPTURE_SELECT, 1);
    wr(8'h90, 32'h0000_0010);
    wr(IDX_MAIN_COUNTER, 0);
    wr(IDX_ACTION_LOWER, 3);
    wr(IDX_EDGE_LOWER, 4);
    // Pin 1 must stay an input or its rising edge never reaches the detector
    port_direction <= 8'($urandom) & 8'hfc;
    wr(IDX_SYSTEM_CONTROL, 32'h0000_0080);
    repeat (40) @(posedge aclk);
    ext_v <= 8'h02;
    repeat (4) @(posedge aclk);
    chk(timer_port_out[0], 1);
    chk(timer_port_oe, {port_direction[7:1], 1'b1});
    rd(IDX_CHANNEL_FLAGS);
    chk(rdat, 3);
    wr(IDX_CHANNEL_FLAGS, 1);
    rd(IDX_CHANNEL_FLAGS);
    chk(rdat, 2);
    wr(IDX_CHAN_IRQ_EN, 2);
    repeat (2) @(posedge aclk);
    chk(channel_irq, 2);
    wr(IDX_MAIN_COUNTER, 32'h0000_fff0);
    repeat (40) @(posedge aclk);
    rd(IDX_OVERFLOW_FLAGS);
    chk(rdat, 32'h0000_0080);
    wr(IDX_MISC_CONTROL, 32'h0000_00b8);
    repeat (2) @(posedge aclk);
    chk(overflow_irq, 1);
    wr(IDX_SYSTEM_CONTROL, 32'h0000_0090);
    rd(IDX_MAIN_COUNTER);
    rd(IDX_OVERFLOW_FLAGS);
    chk(rdat, 0);
    rd(8'h92);
    rd(IDX_CHANNEL_FLAGS);
    chk(rdat[1], 0);
    wr(IDX_CAPTURE_SELECT, 32'h0000_0081);
    wr(8'h9e, 32'h0000_0010);
    // Channel 7 compare with no action and its own mask bit clear
    wr(IDX_COMPARE7_MASK, 5);
    wr(IDX_COMPARE7_DATA, 4);
    wr(IDX_MAIN_COUNTER, 0);
    repeat (40) @(posedge aclk);
    chk(timer_port_out[2:0], 4);
    rd(IDX_MAIN_COUNTER);
    chk(rdat < 32'h11, 1);
    wr(IDX_PULSE_COUNT_3, 0);
    $display("compare and flag tests done");
    wr(IDX_SYSTEM_CONTROL, 32'h0000_00c0);
    wait_mode <= 1;
    repeat (8) @(posedge aclk);
    chk(accum_halt & modulus_halt, 1);
    wait_mode <= 0;
    $display("wait test done");
    stop_test();
  end
  initial begin
    #400000;
    errors++;
    stop_test();
  end
endmodule : mtc_main_timer_core_tb

// ### sim/mtc_pin_model.sv
`timescale 1ns/1ps
module mtc_pin_model (
  input  wire logic       aclk,
  input  wire logic [7:0] ext_v,
  input  wire logic [7:0] timer_port_out,
  input  wire logic [7:0] timer_port_oe,
  output logic      [7:0] timer_port_in
);
  // Timer drive wins over the outside driver on any pin it enables
  assign timer_port_in = (timer_port_oe & timer_port_out) | (~timer_port_oe & ext_v);
endmodule : mtc_pin_model
